// ===== pvit_pkg.sv
// shared constants and carrier types for the panel video input timing block
`default_nettype none
package pvit_pkg;
   // colour depth per primary
   localparam int COLOR_BITS = 10;
   localparam int PORTS = 4;
   // reference clock rate
   localparam int REF_CLK_MHZ = 125;
   // black insertion time after a mode change, in ms
   localparam int BLACK_TIME_MS = 650;
   // cycles of black insertion, an exact product with no rounding
   localparam int BLACK_CYCLES = BLACK_TIME_MS * REF_CLK_MHZ * 1000;
   // line and frame geometry
   localparam int ACTIVE_LINES = 1080;
   localparam int ACTIVE_CLKS = 480;
   // strobe-free link clocks that mark a blank line
   localparam int BLANK_LINE_CLKS = 2 * ACTIVE_CLKS;
   localparam int CNT_W = 12;
   localparam logic [11:0] CNT_ZERO = 12'h000;
   localparam logic [11:0] CNT_ONE = 12'h001;
   localparam logic [11:0] CNT_MAX = 12'hFFF;
   // one pixel per port
   typedef struct packed {
      logic [9:0] red;
      logic [9:0] green;
      logic [9:0] blue;
   } pvit_pixel_t;
   // four ports of pixels in round-robin order
   typedef struct packed {
      pvit_pixel_t [3:0] port;
   } pvit_quad_t;
   // measured timing
   typedef struct packed {
      logic [11:0] vertical_total_lines;
      logic [11:0] horizontal_total_clocks;
   } pvit_meas_t;
   // mode control states
   typedef enum logic [1:0] {MS_RUN, MS_BLACK} pvit_mode_t;
endpackage
`default_nettype wire

// ===== pvit_sync2.sv
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module pvit_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // async in, synced out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   // first stage, read only by the second
   logic [W-1:0] meta_q;
   // two flops in series
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== pvit_top.sv
// panel side video input timing: link sampling, timing measure, black insertion
`timescale 1ns/100ps
`default_nettype none
// How it works
// - enable-only; sync inputs ignored, held low
// - excess jitter can break panel operation; nothing here guards against it
// - mode change shows black, loads parameters
// - black interval longer than 650 ms
// - only select pin picks 2D or 3D
// - colours are 10-bit, higher is brighter
module pvit_top #(
   parameter int BLACK_CYC = pvit_pkg::BLACK_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // link inputs from the video source
   input wire logic link_clk,
   input wire logic pixel_valid_strobe,
   input wire logic hsync_in,
   input wire logic vsync_in,
   input wire pvit_pkg::pvit_quad_t pix_in,
   // mode select pin
   input wire logic stereo_select_pin,
   // output video toward the panel drivers
   output pvit_pkg::pvit_quad_t pix_out,
   output logic pix_out_valid,
   // status
   output logic stereo_mode,
   output logic black_active,
   output logic param_load,
   output logic sync_misuse,
   output pvit_pkg::pvit_meas_t meas
);
   // synchronised link signals
   logic clk_s, strobe_s, hs_s, vs_s, sel_s;
   pvit_pkg::pvit_quad_t pix_s;
   pvit_sync2 #(.W(5 + $bits(pvit_pkg::pvit_quad_t))) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .async_in({link_clk, pixel_valid_strobe, hsync_in, vsync_in, stereo_select_pin, pix_in}),
      .sync_out({clk_s, strobe_s, hs_s, vs_s, sel_s, pix_s})
   );
   // link clock edge finding
   logic clk_prev_q, strobe_prev_q;
   logic rise;
   assign rise = clk_s & ~clk_prev_q;
   // history of link clock and strobe
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         clk_prev_q <= 1'b0;
         strobe_prev_q <= 1'b0;
      end else begin
         clk_prev_q <= clk_s;
         if (rise) begin
            strobe_prev_q <= strobe_s;
         end
      end
   end
   // line and frame counters, measured by strobe only
   logic [11:0] hcnt_q, vcnt_q, blank_q;
   logic frame_start;
   assign frame_start = rise & strobe_s & ~strobe_prev_q & (blank_q > pvit_pkg::CNT_ONE) &
                        (vcnt_q >= 12'(pvit_pkg::ACTIVE_LINES));
   // counting clocks per line, lines per frame
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         hcnt_q <= pvit_pkg::CNT_ZERO;
         vcnt_q <= pvit_pkg::CNT_ZERO;
         blank_q <= pvit_pkg::CNT_ZERO;
         meas <= '0;
      end else if (rise) begin
         if (strobe_s & ~strobe_prev_q) begin
            // line start: latch previous line length
            meas.horizontal_total_clocks <= hcnt_q;
            hcnt_q <= pvit_pkg::CNT_ONE;
            blank_q <= pvit_pkg::CNT_ZERO;
            if (frame_start) begin
               meas.vertical_total_lines <= vcnt_q;
               vcnt_q <= pvit_pkg::CNT_ONE;
            end else if (vcnt_q != pvit_pkg::CNT_MAX) begin
               vcnt_q <= vcnt_q + pvit_pkg::CNT_ONE;
            end
         end else begin
            if (hcnt_q != pvit_pkg::CNT_MAX) begin
               hcnt_q <= hcnt_q + pvit_pkg::CNT_ONE;
            end
            // long blank marks vertical blanking
            if (~strobe_s && hcnt_q > 12'(pvit_pkg::BLANK_LINE_CLKS) &&
                blank_q != pvit_pkg::CNT_MAX) begin
               blank_q <= blank_q + pvit_pkg::CNT_ONE;
               hcnt_q <= pvit_pkg::CNT_ZERO;
            end
         end
      end
   end
   // sync pins must sit low; flag misuse but never act on it
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sync_misuse <= 1'b0;
      end else begin
         sync_misuse <= hs_s | vs_s;
      end
   end
   // mode control and black insertion
   pvit_pkg::pvit_mode_t state_q;
   logic [31:0] black_cnt_q;
   // select pin alone chooses the mode
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_q <= pvit_pkg::MS_RUN;
         stereo_mode <= 1'b0;
         black_cnt_q <= '0;
         black_active <= 1'b0;
         param_load <= 1'b0;
      end else begin
         param_load <= 1'b0;
         case (state_q)
            pvit_pkg::MS_RUN: begin
               if (sel_s != stereo_mode) begin
                  stereo_mode <= sel_s;
                  state_q <= pvit_pkg::MS_BLACK;
                  black_cnt_q <= '0;
                  black_active <= 1'b1;
                  param_load <= 1'b1;
               end
            end
            pvit_pkg::MS_BLACK: begin
               // another change restarts the black interval
               if (sel_s != stereo_mode) begin
                  stereo_mode <= sel_s;
                  black_cnt_q <= '0;
                  param_load <= 1'b1;
               end else if (black_cnt_q >= 32'(BLACK_CYC)) begin
                  state_q <= pvit_pkg::MS_RUN;
                  black_active <= 1'b0;
               end else begin
                  black_cnt_q <= black_cnt_q + 32'h0000_0001;
               end
            end
            default: begin
               state_q <= pvit_pkg::MS_RUN;
            end
         endcase
      end
   end
   // pixel output: four ports passed in order, black while inserting
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pix_out <= '0;
         pix_out_valid <= 1'b0;
      end else begin
         pix_out_valid <= rise & strobe_s;
         if (rise) begin
            pix_out <= black_active ? '0 : pix_s;
         end
      end
   end
   // black held for at least 8 cycles after a change
   black_min_a: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(black_active) |-> black_active [*8])
      else $error("black interval ended early");
   // output black while inserting
   black_pix_a: assert property (@(posedge ref_clk) disable iff (reset)
      black_active && $past(black_active) && $past(rise) |-> pix_out == '0)
      else $error("pixels not black during insertion");
   // parameter load pulses with change
   load_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
      param_load |-> black_active ##1 !param_load || $past(sel_s) != $past(stereo_mode))
      else $error("parameter load not a pulse");
   // mode follows pin
   mode_follow_a: assert property (@(posedge ref_clk) disable iff (reset)
      $changed(stereo_mode) |-> black_active && stereo_mode == $past(sel_s))
      else $error("mode changed without pin");
   // sync misuse flag tracks pins
   sync_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
      sync_misuse == $past(hs_s | vs_s))
      else $error("sync misuse flag wrong");
   // valid only on a link edge with strobe
   valid_edge_a: assert property (@(posedge ref_clk) disable iff (reset)
      pix_out_valid |-> $past(rise) && $past(strobe_s))
      else $error("valid without strobe edge");
   // line length latched at line start
   line_meas_a: assert property (@(posedge ref_clk) disable iff (reset)
      rise && strobe_s && !strobe_prev_q |=> meas.horizontal_total_clocks == $past(hcnt_q))
      else $error("line length not captured");
   // black ends only after count
   black_end_a: assert property (@(posedge ref_clk) disable iff (reset)
      $fell(black_active) |-> $past(black_cnt_q) >= 32'(BLACK_CYC))
      else $error("black ended before count");
   // one cycle after a pin change: black on, load pulse, new mode
   sequence black_entry_s;
      black_active && param_load && stereo_mode == $past(sel_s);
   endsequence
   // a change seen while running starts black insertion at once
   black_entry_a: assert property (@(posedge ref_clk) disable iff (reset)
      state_q == pvit_pkg::MS_RUN && sel_s != stereo_mode |=> black_entry_s)
      else $error("mode change did not start black");
endmodule
`default_nettype wire

// ===== pvit_src_model.sv
// behavioural video source driving the four link ports
`timescale 1ns/100ps
`default_nettype none
module pvit_src_model (
   // control from the bench
   input wire logic run,
   // vertical timing is not modelled: a run is far shorter than a frame
   input wire logic blank,
   input wire logic bad_sync,
   input wire pvit_pkg::pvit_quad_t px,
   // link outputs toward the panel
   output logic link_clk,
   output logic pixel_valid_strobe,
   output logic hsync_in,
   output logic vsync_in,
   output pvit_pkg::pvit_quad_t pix_in
);
   // link clock, unrelated in phase, parked low while run is low
   // stretched fixed period stands in for the pixel clock
   // no spread and no frame-to-frame jitter
   initial begin
      link_clk = 1'b0;
      pixel_valid_strobe = 1'b0; // low from time zero
      pix_in = '0;
      #3;
      forever begin
         #40;
         if (run || link_clk) begin
            link_clk = ~link_clk;
            // launch on the falling edge here, half a period before the rising edge that the panel samples
            if (!link_clk) begin
               pixel_valid_strobe <= run & ~blank;
               // idle or blanking bus shows the inverse of the last value
               pix_in <= (run & ~blank) ? px : ~pix_in;
            end
         end
      end
   end
   // vsync held low; hsync low unless the bench asks for misuse
   assign hsync_in = bad_sync;
   assign vsync_in = 1'b0;
endmodule
`default_nettype wire

// ===== tb_pvit_top.sv
// self-checking bench for the panel video input timing block
`timescale 1ns/100ps
`default_nettype none
module tb_pvit_top;
   localparam int BC = 50; // shortened black time
   logic ref_clk, reset, run, bad_sync, stereo_select_pin, link_clk, pixel_valid_strobe;
   logic hs, vs, vld, st, blk, pl, mis, blank;
   pvit_pkg::pvit_quad_t px, pix_in, pix_out, v;
   pvit_pkg::pvit_meas_t meas;
   int err_count, checked, n, k;
   // far side source
   pvit_src_model i_src (.run(run), .blank(blank), .bad_sync(bad_sync), .px(px),
      .link_clk(link_clk), .pixel_valid_strobe(pixel_valid_strobe), .hsync_in(hs),
      .vsync_in(vs), .pix_in(pix_in));
   pvit_top #(.BLACK_CYC(BC)) i_dut (.ref_clk(ref_clk), .reset(reset), .link_clk(link_clk),
      .pixel_valid_strobe(pixel_valid_strobe), .hsync_in(hs), .vsync_in(vs), .pix_in(pix_in),
      .stereo_select_pin(stereo_select_pin), .pix_out(pix_out), .pix_out_valid(vld),
      .stereo_mode(st), .black_active(blk), .param_load(pl), .sync_misuse(mis), .meas(meas));
   // 125 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // compare and count
   task automatic chk(input logic [159:0] seen, input logic [159:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // step past edges, sample settled values
   task automatic tick(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask
   // bounded wait for a fresh valid pulse
   task automatic wait_vld;
      int i;
      tick(1);
      for (i = 0; i < 60 && vld !== 1'b1; i++) tick(1);
      chk(vld, 1'b1);
   endtask
   // one quad passes unchanged, port order kept
   task automatic t_pass(input pvit_pkg::pvit_quad_t q);
      @(posedge ref_clk);
      px <= q;
      repeat (3) wait_vld;
      chk(pix_out, q);
   endtask
   // mode change: black for the set time, one load pulse, zeros shown
   task automatic t_mode(input logic lvl);
      @(posedge ref_clk);
      stereo_select_pin <= lvl;
      for (n = 0; n < 10 && st !== lvl; n++) tick(1);
      chk({st, blk, pl}, {lvl, 2'b11});
      for (n = 0; n < 200 && blk === 1'b1; n++) begin
         // first sample may still carry a pixel taken before black began
         if (vld === 1'b1 && n > 0) chk(pix_out, '0);
         if (n == 1) chk(pl, 1'b0);
         tick(1);
      end
      chk(160'(n), 160'(BC + 1));
   endtask
   // hsync line high: flagged, pixels still flow
   task automatic t_sync;
      @(posedge ref_clk);
      bad_sync <= 1'b1;
      tick(8);
      chk(mis, 1'b1);
      t_pass({4{30'h2AA_5555}});
      chk(blk, 1'b0);
      @(posedge ref_clk);
      bad_sync <= 1'b0;
      tick(4);
      chk(mis, 1'b0);
   endtask
   // one line of 480 active and 40 blank clocks between two line starts
   task automatic t_line;
      @(posedge link_clk);
      blank <= 1'b1;
      repeat (40) @(posedge link_clk);
      blank <= 1'b0;
      repeat (pvit_pkg::ACTIVE_CLKS) @(posedge link_clk);
      blank <= 1'b1;
      repeat (40) @(posedge link_clk);
      blank <= 1'b0;
      repeat (2) @(posedge link_clk);
      chk(meas.horizontal_total_clocks, 12'(pvit_pkg::ACTIVE_CLKS + 40));
      // far fewer than a frame of lines: no frame total yet
      chk(meas.vertical_total_lines, 12'h000);
   endtask
   // verdict
   task automatic test_done;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // watchdog
   initial begin
      #400000;
      err_count++;
      test_done;
   end
   // main sequence
   initial begin
      reset = 1'b1;
      run = 1'b0;
      bad_sync = 1'b0;
      blank = 1'b0;
      stereo_select_pin = 1'b0;
      px = '0;
      err_count = 0;
      checked = 0;
      tick(20);
      chk({pix_out, vld, st, blk, pl, mis, meas}, '0);
      reset <= 1'b0;
      run <= 1'b1;
      for (k = 0; k < 4; k++) begin
         v = '0;
         v.port[k] = {10'h3FF, 10'h155, 10'h001};
         t_pass(v);
      end
      t_mode(1'b1);
      t_pass({4{30'h3FF_FFFF}});
      t_mode(1'b0);
      t_sync;
      t_line;
      test_done;
   end
endmodule
`default_nettype wire
